// ### fsp_dev.sv
// fsp_dev: device end, byte shifters on the link clock, command interpreter on ref_clk
// assumes a flash array controller answers flash_req with a one-cycle flash_ack
// Summary of operation
// RQ1 - receive bits on rising transfer clock
// RQ2 - drive transmit bits on falling clock
// RQ3 - eight-bit bytes, least significant bit first
// RQ4 - hold-off high while busy, low when ready
// RQ5 - programmer waits for hold-off low
// RQ6 - FF reads, 41 programs a 256-byte page
// RQ7 - middle byte A8-A15, high byte A16-A23
// RQ8 - programmer sends zero high address byte
// RQ9 - no block erase; four extra commands
// RQ10 - FB returns eight version bytes
// RQ11 - FC outputs one boot area page
// RQ12 - unverified: only status, ID, version
// RQ13 - blank flash accepts every command
// RQ14 - only status, read, version bytes return
// RQ15 - F5 takes address, size, up to seven IDs
// RQ16 - FA takes size, checksum, program data
// RQ17 - 70 returns primary then secondary status
// RQ18 - reset held low twenty clock periods
// RQ19 - strap and clock high at reset release
// RQ20 - A7 erases all only after D0
// RQ21 - 50 clears errors then drops hold-off
// RQ22 - unknown first byte is ignored
// RQ23 - refused command consumes no operands
module fsp_dev import fsp_pkg::*; #(
  // version text, value arbitrary
  parameter logic [63:0] VERSION = 64'h3130_3056_5053_4631
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  fsp_link_if.dev          link,
  output logic             flash_req,
  output fsp_fop_e         flash_op,
  output logic [15:0]      flash_addr,
  output logic [7:0]       flash_wdata,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic        flash_ack,
  input  wire logic        flash_fail,
  input  wire logic        flash_blank,
  input  wire logic [55:0] id_code,
  output logic             dl_valid,
  output logic [7:0]       dl_data,
  output logic             dl_done,
  output logic             dl_sum_ok
);
  typedef struct packed {
    fsp_dstate_e st;
    logic        armed;
    logic        mode_on;
    logic        link_rst;
    logic        tog_q;
    logic        busy;
    logic [7:0]  tx_byte;
    logic [7:0]  cmd;
    logic [8:0]  idx;
    logic [15:0] len;
    logic [7:0]  page;
    logic [7:0]  chk;
    logic [7:0]  sum;
    logic        id_match;
    logic        id_ok;
    logic        sum_ok;
    logic        err_erase;
    logic        err_prog;
    logic        req;
    fsp_fop_e    op;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        dl_valid;
    logic [7:0]  dl_data;
    logic        dl_done;
  } fsp_dref_s;
  typedef struct packed {
    logic [2:0] bitc;
    logic [7:0] sh;
    logic [7:0] data;
    logic       tog;
  } fsp_drx_s;
  typedef struct packed {
    logic [2:0] bitc;
    logic       txd;
  } fsp_dtx_s;

  fsp_dref_s   r;
  fsp_dref_s   next_r;
  fsp_drx_s    rx;
  fsp_drx_s    next_rx;
  fsp_dtx_s    tx;
  fsp_dtx_s    next_tx;
  logic [2:0]  s_ref;
  logic        s_srst;
  logic        hold;
  logic        ev;
  logic        open;
  logic [7:0]  b;
  logic [7:0]  prim;
  logic [7:0]  sec;
  logic [63:0] vsh;
  logic [55:0] ish;
  logic [2:0]  ipos;
  logic        id_eq;

  fsp_sync #(.W(3)) u_sync_ref (
    .clk  (ref_clk),
    .din  ({rx.tog, link.reset_n, link.entry_strap_pin}),
    .dout (s_ref)
  );
  fsp_sync #(.W(1)) u_sync_link (
    .clk  (link.sclk),
    .din  (r.link_rst),
    .dout (s_srst)
  );

  // RQ1 rising edge capture, RQ3 lsb first
  always_comb begin
    next_rx      = rx;
    next_rx.bitc = rx.bitc + 3'h1;
    next_rx.sh   = {link.rxd, rx.sh[7:1]};
    if (rx.bitc == BIT_LAST) begin
      next_rx.data = {link.rxd, rx.sh[7:1]};
      next_rx.tog  = ~rx.tog;
    end
  end
  always_ff @(posedge link.sclk) begin
    if (s_srst) rx <= '0;
    else rx <= next_rx;
  end

  // RQ2 falling edge drive; tx_byte only changes while hold-off is high
  always_comb begin
    next_tx.bitc = tx.bitc + 3'h1;
    next_tx.txd  = r.tx_byte[tx.bitc];
  end
  always_ff @(negedge link.sclk) begin
    if (s_srst) begin
      tx     <= '0;
      tx.txd <= 1'b1;
    end else begin
      tx <= next_tx;
    end
  end

  assign hold = rst | ~s_ref[1];
  assign ev   = s_ref[2] ^ r.tog_q;
  assign b    = rx.data;

  always_comb begin
    next_r          = r;
    next_r.dl_valid = 1'b0;
    next_r.dl_done  = 1'b0;
    next_r.link_rst = 1'b0;
    next_r.tog_q    = s_ref[2];
    // RQ13 blank flash lifts the lock
    open                = r.id_ok | flash_blank;
    prim                = STAT_RESET;
    prim[ST_ERASE_ERR]  = r.err_erase;
    prim[ST_PROG_ERR]   = r.err_prog;
    sec                 = ZERO_BYTE;
    sec[ST1_ID_OK]      = r.id_ok;
    sec[ST1_SUM_OK]     = r.sum_ok;
    vsh   = VERSION >> {r.idx[2:0], 3'h0};
    ipos  = 3'(r.idx - IDX_ID_FIRST);
    ish   = id_code >> {ipos, 3'h0};
    id_eq = r.id_match & (b == ish[7:0]);
    if (r.armed) begin
      next_r.armed   = 1'b0;
      next_r.mode_on = s_ref[0];
    end
    case (r.st)
      DS_IDLE: begin
        // RQ4 high from the received byte until handled
        next_r.busy = ~r.mode_on;
        if (ev && r.mode_on) begin
          next_r.busy = 1'b1;
          next_r.st   = DS_STEP;
        end
      end
      DS_STEP: begin
        next_r.st   = DS_IDLE;
        next_r.busy = 1'b0;
        next_r.idx  = r.idx + 9'h001;
        if (r.idx == '0) begin
          next_r.cmd      = b;
          next_r.id_match = 1'b1;
          next_r.len      = '0;
          // RQ9 RQ12 RQ22 RQ23 decode and lock
          case (b)
            CMD_READ_STAT: next_r.tx_byte = prim;
            CMD_VERSION:   next_r.tx_byte = VERSION[7:0];
            CMD_ID_CHECK:  next_r.id_match = 1'b1;
            CMD_CLR_STAT: begin
              next_r.idx = '0;
              // RQ21 clear errors
              if (open) begin
                next_r.err_erase = 1'b0;
                next_r.err_prog  = 1'b0;
                next_r.sum_ok    = 1'b0;
              end
            end
            CMD_PAGE_READ, CMD_PAGE_PROG, CMD_ERASE_ALL, CMD_DOWNLOAD, CMD_BOOT_OUT: begin
              if (!open) next_r.idx = '0;
            end
            default: next_r.idx = '0;
          endcase
        end else begin
          case (r.cmd)
            // RQ17 secondary follows primary
            CMD_READ_STAT: begin
              if (r.idx == IDX_STAT2) next_r.tx_byte = sec;
              else next_r.idx = '0;
            end
            // RQ10 eight version bytes
            CMD_VERSION: begin
              if (r.idx == IDX_VER_LAST) next_r.idx = '0;
              else next_r.tx_byte = vsh[7:0];
            end
            // RQ20 erase only on confirm
            CMD_ERASE_ALL: begin
              next_r.idx = '0;
              if (b == ERASE_CONFIRM) begin
                next_r.req  = 1'b1;
                next_r.op   = FOP_ERASE;
                next_r.busy = 1'b1;
                next_r.st   = DS_FLASH;
              end
            end
            // RQ6 RQ7 RQ11 page output from address middle byte
            CMD_PAGE_READ, CMD_BOOT_OUT: begin
              if (r.idx == IDX_ADDR_MID) next_r.page = b;
              if (r.idx == IDX_PAGE_LAST) next_r.idx = '0;
              else if (r.idx >= IDX_ADDR_HIGH) begin
                next_r.req  = 1'b1;
                next_r.op   = (r.cmd == CMD_BOOT_OUT) ? FOP_BOOT : FOP_READ;
                next_r.addr = {r.page, 8'(r.idx - IDX_ADDR_HIGH)};
                next_r.busy = 1'b1;
                next_r.st   = DS_FLASH;
              end
            end
            // RQ6 RQ7 page program byte by byte
            CMD_PAGE_PROG: begin
              if (r.idx == IDX_ADDR_MID) next_r.page = b;
              if (r.idx == IDX_PAGE_LAST) next_r.idx = '0;
              if (r.idx >= IDX_DATA_FIRST) begin
                next_r.req   = 1'b1;
                next_r.op    = FOP_PROG;
                next_r.addr  = {r.page, 8'(r.idx - IDX_DATA_FIRST)};
                next_r.wdata = b;
                next_r.busy  = 1'b1;
                next_r.st    = DS_FLASH;
              end
            end
            // RQ15 address, size, then id bytes
            CMD_ID_CHECK: begin
              if (r.idx == IDX_ID_SIZE) begin
                next_r.len = ({8'h00, b} > ID_MAX_LEN) ? ID_MAX_LEN : {8'h00, b};
                if (b == ZERO_BYTE) begin
                  next_r.id_ok = 1'b0;
                  next_r.idx   = '0;
                end
              end else if (r.idx >= IDX_ID_FIRST) begin
                next_r.id_match = id_eq;
                next_r.len      = r.len - LEN_ONE;
                if (r.len == LEN_ONE) begin
                  next_r.id_ok = id_eq;
                  next_r.idx   = '0;
                end
              end
            end
            // RQ16 size, checksum, data
            CMD_DOWNLOAD: begin
              if (r.idx == IDX_DL_SIZE_LO) next_r.len[7:0] = b;
              if (r.idx == IDX_DL_SIZE_HI) next_r.len[15:8] = b;
              if (r.idx == IDX_DL_CHK) begin
                next_r.chk = b;
                next_r.sum = ZERO_BYTE;
                if (r.len == '0) begin
                  next_r.dl_done = 1'b1;
                  next_r.sum_ok  = (b == ZERO_BYTE);
                  next_r.idx     = '0;
                end
              end
              if (r.idx == IDX_DL_DATA) begin
                next_r.idx      = r.idx;
                next_r.dl_valid = 1'b1;
                next_r.dl_data  = b;
                next_r.sum      = r.sum + b;
                next_r.len      = r.len - LEN_ONE;
                if (r.len == LEN_ONE) begin
                  next_r.dl_done = 1'b1;
                  next_r.sum_ok  = (8'(r.sum + b) == r.chk);
                  next_r.idx     = '0;
                end
              end
            end
            default: next_r.idx = '0;
          endcase
        end
      end
      DS_FLASH: begin
        if (flash_ack) begin
          next_r.req  = 1'b0;
          next_r.busy = 1'b0;
          next_r.st   = DS_IDLE;
          if (r.op == FOP_READ || r.op == FOP_BOOT) next_r.tx_byte = flash_rdata;
          if (r.op == FOP_ERASE) next_r.err_erase = r.err_erase | flash_fail;
          if (r.op == FOP_PROG) next_r.err_prog = r.err_prog | flash_fail;
        end
      end
      default: next_r.st = DS_IDLE;
    endcase
  end

  // RQ18 RQ19 strap caught after the release of reset
  always_ff @(posedge ref_clk) begin
    if (hold) begin
      r          <= '0;
      r.st       <= DS_IDLE;
      r.busy     <= 1'b1;
      r.armed    <= 1'b1;
      r.link_rst <= 1'b1;
      r.tx_byte  <= IDLE_BYTE;
      r.tog_q    <= s_ref[2];
    end else begin
      r <= next_r;
    end
  end

  assign link.transfer_hold_off_out = r.busy;
  assign link.txd                   = tx.txd;
  assign flash_req                  = r.req;
  assign flash_op                   = r.op;
  assign flash_addr                 = r.addr;
  assign flash_wdata                = r.wdata;
  assign dl_valid                   = r.dl_valid;
  assign dl_data                    = r.dl_data;
  assign dl_done                    = r.dl_done;
  assign dl_sum_ok                  = r.sum_ok;
endmodule

// ### fsp_pkg.sv
// fsp_pkg: command codes, byte positions, status fields and timing of the link
// assumes both ends and the testbench import it
package fsp_pkg;
  localparam logic [7:0]  CMD_PAGE_READ  = 8'hFF;
  localparam logic [7:0]  CMD_PAGE_PROG  = 8'h41;
  localparam logic [7:0]  CMD_ERASE_ALL  = 8'hA7;
  localparam logic [7:0]  ERASE_CONFIRM  = 8'hD0;
  localparam logic [7:0]  CMD_READ_STAT  = 8'h70;
  localparam logic [7:0]  CMD_CLR_STAT   = 8'h50;
  localparam logic [7:0]  CMD_ID_CHECK   = 8'hF5;
  localparam logic [7:0]  CMD_DOWNLOAD   = 8'hFA;
  localparam logic [7:0]  CMD_VERSION    = 8'hFB;
  localparam logic [7:0]  CMD_BOOT_OUT   = 8'hFC;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  localparam logic [7:0]  IDLE_BYTE      = 8'hFF;
  localparam logic [2:0]  BIT_LAST       = 3'h7;
  // byte index inside a command, the command byte being index 0
  localparam logic [8:0]  IDX_ADDR_MID   = 9'h001;
  localparam logic [8:0]  IDX_ADDR_HIGH  = 9'h002;
  localparam logic [8:0]  IDX_DATA_FIRST = 9'h003;
  localparam logic [8:0]  IDX_PAGE_LAST  = 9'h102;
  localparam logic [8:0]  IDX_STAT2      = 9'h001;
  localparam logic [8:0]  IDX_VER_LAST   = 9'h008;
  localparam logic [8:0]  IDX_ID_SIZE    = 9'h004;
  localparam logic [8:0]  IDX_ID_FIRST   = 9'h005;
  localparam logic [8:0]  IDX_DL_SIZE_LO = 9'h001;
  localparam logic [8:0]  IDX_DL_SIZE_HI = 9'h002;
  localparam logic [8:0]  IDX_DL_CHK     = 9'h003;
  localparam logic [8:0]  IDX_DL_DATA    = 9'h004;
  localparam logic [15:0] ID_MAX_LEN     = 16'h0007;
  localparam logic [15:0] LEN_ONE        = 16'h0001;
  // status bytes
  localparam logic [7:0]  STAT_RESET     = 8'h80;
  localparam int          ST_ERASE_ERR   = 5;
  localparam int          ST_PROG_ERR    = 4;
  localparam int          ST1_ID_OK      = 3;
  localparam int          ST1_SUM_OK     = 4;
  // host side byte positions and timing, in ref_clk cycles
  localparam logic [2:0]  HPOS_PAGE_HIGH = 3'h2;
  localparam logic [2:0]  HPOS_ID_HIGH   = 3'h3;
  localparam logic [2:0]  HPOS_MAX       = 3'h7;
  // start count of the two idle clock pulses sent after reset release
  localparam logic [2:0]  FLUSH_BITC     = 3'h6;
  localparam int          RST_MIN_CYC    = 20;
  localparam logic [7:0]  RST_HOLD_CYC   = 8'(3 * RST_MIN_CYC);
  localparam logic [7:0]  HALF_DIV_M1    = 8'h03;
  localparam logic [7:0]  GUARD_CYC      = 8'h0C;
  typedef enum logic [1:0] {
    FOP_READ  = 2'h0,
    FOP_PROG  = 2'h1,
    FOP_ERASE = 2'h2,
    FOP_BOOT  = 2'h3
  } fsp_fop_e;
  typedef enum logic [2:0] {
    DS_IDLE  = 3'h1,
    DS_STEP  = 3'h2,
    DS_FLASH = 3'h4
  } fsp_dstate_e;
  typedef enum logic [4:0] {
    HS_RST   = 5'h01,
    HS_IDLE  = 5'h02,
    HS_WAIT  = 5'h04,
    HS_SHIFT = 5'h08,
    HS_GUARD = 5'h10
  } fsp_hstate_e;
endpackage

// ### fsp_link_if.sv
// fsp_link_if: the four-wire serial link plus reset and entry strap
// assumes the host drives sclk, rxd, reset_n and strap, the device txd and busy
interface fsp_link_if;
  logic sclk;
  logic rxd;
  logic txd;
  logic transfer_hold_off_out;
  logic reset_n;
  logic entry_strap_pin;
  modport dev (
    input  sclk,
    input  rxd,
    input  reset_n,
    input  entry_strap_pin,
    output txd,
    output transfer_hold_off_out
  );
  modport host (
    output sclk,
    output rxd,
    output reset_n,
    output entry_strap_pin,
    input  txd,
    input  transfer_hold_off_out
  );
endinterface

// ### fsp_sync.sv
// fsp_sync: two-flop level synchroniser, one per bit
// assumes each bit is a level or a toggle from another domain
module fsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] q1;
    logic [W-1:0] q2;
  } fsp_sync_s;
  fsp_sync_s r;
  fsp_sync_s next_r;
  always_comb begin
    next_r.q1 = din;
    next_r.q2 = r.q1;
  end
  always_ff @(posedge clk) begin
    r <= next_r;
  end
  assign dout = r.q2;
endmodule

// ### fsp_host.sv
// fsp_host: programmer end, makes the transfer clock from ref_clk and moves one byte per request
// assumes the user holds xfer_valid and its data until xfer_ready is seen
module fsp_host import fsp_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  fsp_link_if.host        link,
  input  wire logic       xfer_valid,
  input  wire logic [7:0] xfer_data,
  input  wire logic       xfer_first,
  output logic            xfer_ready,
  output logic            recv_valid,
  output logic [7:0]      recv_data
);
  typedef struct packed {
    fsp_hstate_e st;
    logic        sclk;
    logic        rxd;
    logic        reset_n;
    logic [7:0]  div;
    logic [7:0]  cnt;
    logic [2:0]  bitc;
    logic [7:0]  sh_out;
    logic [7:0]  sh_in;
    logic [7:0]  hcmd;
    logic [2:0]  pos;
    logic        ready;
    logic        flush;
    logic        recv_valid;
    logic [7:0]  recv_data;
  } fsp_host_s;

  fsp_host_s  r;
  fsp_host_s  next_r;
  logic [1:0] s_in;
  logic       zero_hi;
  logic       page_cmd;

  fsp_sync #(.W(2)) u_sync (
    .clk  (ref_clk),
    .din  ({link.transfer_hold_off_out, link.txd}),
    .dout (s_in)
  );

  always_comb begin
    next_r            = r;
    next_r.recv_valid = 1'b0;
    page_cmd = (r.hcmd == CMD_PAGE_READ) || (r.hcmd == CMD_PAGE_PROG)
               || (r.hcmd == CMD_BOOT_OUT);
    // RQ8 high address byte forced to zero
    zero_hi  = !xfer_first && ((page_cmd && r.pos == HPOS_PAGE_HIGH)
               || (r.hcmd == CMD_ID_CHECK && r.pos == HPOS_ID_HIGH));
    case (r.st)
      // RQ18 RQ19 reset low long enough, clock parked high at release
      HS_RST: begin
        next_r.cnt = r.cnt + 8'h01;
        next_r.div = r.div - 8'h01;
        if (r.div == '0) begin
          next_r.div  = HALF_DIV_M1;
          next_r.sclk = ~r.sclk;
        end
        // two idle pulses after release let the device's link-side reset run out
        if (r.cnt == RST_HOLD_CYC) begin
          next_r.sclk    = 1'b1;
          next_r.reset_n = 1'b1;
          next_r.sh_out  = IDLE_BYTE;
          next_r.flush   = 1'b1;
          next_r.st      = HS_WAIT;
        end
      end
      HS_IDLE: begin
        if (xfer_valid) begin
          next_r.ready  = 1'b0;
          next_r.sh_out = zero_hi ? ZERO_BYTE : xfer_data;
          next_r.pos    = (r.pos == HPOS_MAX) ? r.pos : r.pos + 3'h1;
          if (xfer_first) begin
            next_r.hcmd = xfer_data;
            next_r.pos  = 3'h1;
          end
          next_r.st = HS_WAIT;
        end
      end
      // RQ5 start only when hold-off is low
      HS_WAIT: begin
        if (!s_in[1]) begin
          next_r.div  = HALF_DIV_M1;
          next_r.bitc = r.flush ? FLUSH_BITC : 3'h0;
          next_r.st   = HS_SHIFT;
        end
      end
      // RQ3 lsb first, data changes on the fall
      HS_SHIFT: begin
        next_r.div = r.div - 8'h01;
        if (r.div == '0) begin
          next_r.div = HALF_DIV_M1;
          if (r.sclk) begin
            next_r.sclk = 1'b0;
            next_r.rxd  = r.sh_out[0];
          end else begin
            next_r.sclk   = 1'b1;
            next_r.sh_out = {1'b1, r.sh_out[7:1]};
            next_r.sh_in  = {s_in[0], r.sh_in[7:1]};
            next_r.bitc   = r.bitc + 3'h1;
            if (r.bitc == BIT_LAST) begin
              next_r.recv_valid = ~r.flush;
              next_r.flush      = 1'b0;
              next_r.recv_data  = {s_in[0], r.sh_in[7:1]};
              next_r.cnt        = GUARD_CYC;
              next_r.st         = HS_GUARD;
            end
          end
        end
      end
      HS_GUARD: begin
        next_r.rxd = 1'b1;
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == '0) begin
          next_r.ready = 1'b1;
          next_r.st    = HS_IDLE;
        end
      end
      default: next_r.st = HS_RST;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r      <= '0;
      r.st   <= HS_RST;
      r.sclk <= 1'b1;
      r.rxd  <= 1'b1;
      r.div  <= HALF_DIV_M1;
    end else begin
      r <= next_r;
    end
  end

  assign link.sclk            = r.sclk;
  assign link.rxd             = r.rxd;
  assign link.reset_n         = r.reset_n;
  assign link.entry_strap_pin = 1'b1;
  assign xfer_ready           = r.ready;
  assign recv_valid           = r.recv_valid;
  assign recv_data            = r.recv_data;
endmodule

// ### fsp_link_assertions.sv
// fsp_link_assertions: timing checks on the link between host and device
// assumes ref_clk clocks both ends and the host makes sclk from it
module fsp_link_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic rxd,
  input wire logic txd,
  input wire logic transfer_hold_off_out,
  input wire logic reset_n,
  input wire logic entry_strap_pin
);
  logic       sclk_q;
  logic [2:0] rises;
  logic [7:0] low_cnt;
  logic [3:0] idle_cnt;
  logic       byte_end;
  // eighth rise of a byte
  assign byte_end = sclk && !sclk_q && rises == 3'h7;
  always_ff @(posedge ref_clk) begin
    sclk_q <= sclk;
    // sclk standing high ends a frame, so release and idle pulses never count as a byte
    if (rst || !sclk) idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hF) idle_cnt <= idle_cnt + 4'h1;
    if (rst || !reset_n || idle_cnt == 4'hF) rises <= 3'h0;
    else if (sclk && !sclk_q) rises <= rises + 3'h1;
    if (rst || reset_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  rx_on_rise_a: assert property ($rose(sclk) |-> $stable(rxd))
    else $error("rxd moved at sclk rise");
  tx_on_fall_a: assert property (reset_n && !$fell(sclk) |-> $stable(txd))
    else $error("txd moved off sclk fall");
  byte_busy_a: assert property (byte_end |-> ##[1:8] transfer_hold_off_out)
    else $error("no hold-off after a byte");
  hold_stall_a: assert property (transfer_hold_off_out && reset_n |-> sclk)
    else $error("sclk moved while held off");
  busy_release_a: assert property (
    $rose(transfer_hold_off_out) && reset_n |-> ##[1:40] !transfer_hold_off_out)
    else $error("hold-off not released");
  reset_busy_a: assert property (!reset_n [*4] |-> transfer_hold_off_out)
    else $error("hold-off low in reset");
  reset_len_a: assert property ($rose(reset_n) |-> low_cnt >= 8'h14)
    else $error("reset pulse too short");
  strap_entry_a: assert property ($rose(reset_n) |-> sclk && entry_strap_pin)
    else $error("strap or sclk low at reset release");
endmodule

// ### serial_flash_programming_cmd_tb.sv
// serial_flash_programming_cmd_tb: both ends joined by the link, flash array modelled here
// assumes the package, link interface, both ends and the checker compile first
module serial_flash_programming_cmd_tb import fsp_pkg::*; ;
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
  timeunit 1ns;
  timeprecision 1ns;
  // version text, value arbitrary
  localparam logic [63:0] VER = 64'h5A4B_3C2D_1E0F_6978;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        xfer_valid = 1'b0;
  logic        xfer_first = 1'b0;
  logic [7:0]  xfer_data = 8'h00;
  logic [7:0]  flash_rdata = 8'h00;
  logic        flash_ack = 1'b0;
  logic        flash_fail = 1'b0;
  logic        flash_blank = 1'b0;
  logic [55:0] id_code = 56'h3CA5960FE17BD2;
  logic [31:0] lfsr = 32'h6B88;
  logic        xfer_ready, recv_valid, dl_valid, dl_done, dl_sum_ok, flash_req;
  logic [7:0]  recv_data, dl_data, flash_wdata;
  logic [15:0] flash_addr;
  fsp_fop_e    flash_op;
  logic [7:0]  tx[$], rx[$], q_wd[$], q_dl[$];
  logic [15:0] q_ad[$];
  fsp_fop_e    q_op[$];
  logic [7:0]  refused[7] = '{8'hFF, 8'h41, 8'hA7, 8'h50, 8'hFA, 8'hFC, 8'h12};
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n_done = 0;

  fsp_link_if link_if ();
  fsp_host fsp_host_i (.ref_clk(ref_clk), .rst(rst), .link(link_if), .xfer_valid(xfer_valid),
    .xfer_data(xfer_data), .xfer_first(xfer_first), .xfer_ready(xfer_ready),
    .recv_valid(recv_valid), .recv_data(recv_data));
  fsp_dev #(.VERSION(VER)) fsp_dev_i (.ref_clk(ref_clk), .rst(rst), .link(link_if),
    .flash_req(flash_req), .flash_op(flash_op), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata), .flash_ack(flash_ack),
    .flash_fail(flash_fail), .flash_blank(flash_blank), .id_code(id_code),
    .dl_valid(dl_valid), .dl_data(dl_data), .dl_done(dl_done), .dl_sum_ok(dl_sum_ok));
  fsp_link_assertions chk_i (.ref_clk(ref_clk), .rst(rst), .sclk(link_if.sclk),
    .rxd(link_if.rxd), .txd(link_if.txd), .transfer_hold_off_out(link_if.transfer_hold_off_out),
    .reset_n(link_if.reset_n), .entry_strap_pin(link_if.entry_strap_pin));

  always #20 ref_clk = ~ref_clk;

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic finish_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // flash array: one-cycle ack, read data derived from address and operation
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 90000) begin
      n_mismatch++;
      finish_test();
    end
    if (dl_valid === 1'b1) q_dl.push_back(dl_data);
    if (dl_done === 1'b1) n_done++;
    if (flash_req === 1'b1 && !flash_ack) begin
      q_op.push_back(flash_op);
      q_ad.push_back(flash_addr);
      q_wd.push_back(flash_wdata);
      #1 flash_ack = 1'b1;
      flash_rdata = flash_addr[7:0] + flash_addr[15:8] + {flash_op, 6'h00};
    end else #1 flash_ack = 1'b0;
  end

  task automatic xb(input logic f, input logic [7:0] d, output logic [7:0] r);
    int t;
    @(posedge ref_clk) #1;
    xfer_valid = 1'b1;
    xfer_first = f;
    xfer_data = d;
    t = 0;
    do @(posedge ref_clk); while (xfer_ready !== 1'b1 && ++t < 200);
    #1 xfer_valid = 1'b0;
    if (t == 200) n_mismatch++;
    t = 0;
    do @(posedge ref_clk); while (recv_valid !== 1'b1 && ++t < 200);
    if (t == 200) n_mismatch++;
    r = recv_data;
  endtask

  task automatic run(input logic [7:0] c);
    logic [7:0] r;
    int t;
    q_op = {};
    q_ad = {};
    q_wd = {};
    q_dl = {};
    rx = {};
    xb(1'b1, c, r);
    foreach (tx[i]) begin
      xb(1'b0, tx[i], r);
      rx.push_back(r);
    end
    t = 0;
    while (xfer_ready !== 1'b1 && t++ < 200) @(posedge ref_clk);
    #1;
  endtask

  task automatic stat(input logic [7:0] p, input logic [7:0] s);
    tx = '{8'h00, 8'h00};
    run(CMD_READ_STAT);
    `CHK("status", p, rx[0])
    `CHK("status1", s, rx[1])
  endtask

  task automatic page(input logic [7:0] c, input fsp_fop_e op);
    logic [7:0] m;
    m = rnd();
    tx = '{m, ZERO_BYTE};
    repeat (256) tx.push_back(rnd());
    run(c);
    `CHK("ops", 256, q_op.size())
    foreach (q_op[i]) begin
      `CHK("op", op, q_op[i])
      `CHK("addr", {m, 8'(i)}, q_ad[i])
      if (op == FOP_PROG) `CHK("wdata", tx[i + 2], q_wd[i])
      else `CHK("rdata", 8'(8'(i) + m + {op, 6'h00}), rx[i + 2])
    end
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    stat(STAT_RESET, ZERO_BYTE);
    tx = {};
    repeat (8) tx.push_back(rnd());
    run(CMD_VERSION);
    foreach (rx[i]) `CHK("version", VER[8 * i +: 8], rx[i])
    tx = {};
    foreach (refused[i]) begin
      run(refused[i]);
      `CHK("refused", 0, q_op.size())
    end
    stat(STAT_RESET, ZERO_BYTE);
    tx = '{rnd(), rnd(), ZERO_BYTE, 8'h07};
    for (int k = 0; k < 7; k++) tx.push_back(id_code[8 * k +: 8]);
    run(CMD_ID_CHECK);
    stat(STAT_RESET, 8'h08);
    page(CMD_PAGE_READ, FOP_READ);
    page(CMD_PAGE_PROG, FOP_PROG);
    page(CMD_BOOT_OUT, FOP_BOOT);
    flash_fail = 1'b1;
    tx = '{8'h55};
    run(CMD_ERASE_ALL);
    `CHK("unconfirmed", 0, q_op.size())
    tx = '{ERASE_CONFIRM};
    run(CMD_ERASE_ALL);
    `CHK("erase", FOP_ERASE, q_op[0])
    flash_fail = 1'b0;
    stat(8'hA0, 8'h08);
    tx = {};
    run(CMD_CLR_STAT);
    stat(STAT_RESET, 8'h08);
    tx = '{8'h03, 8'h00, 8'h00, rnd(), rnd(), rnd()};
    tx[2] = tx[3] + tx[4] + tx[5];
    run(CMD_DOWNLOAD);
    `CHK("dl count", 3, q_dl.size())
    foreach (q_dl[i]) `CHK("dl byte", tx[i + 3], q_dl[i])
    `CHK("dl done", 1, n_done)
    `CHK("dl sum ok", 1'b1, dl_sum_ok)
    stat(STAT_RESET, 8'h18);
    tx = '{ZERO_BYTE, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE};
    run(CMD_ID_CHECK);
    tx = '{ERASE_CONFIRM};
    run(CMD_ERASE_ALL);
    `CHK("locked erase", 0, q_op.size())
    flash_blank = 1'b1;
    run(CMD_ERASE_ALL);
    `CHK("blank erase", 1, q_op.size())
    finish_test();
  end
endmodule
